// ===== epas_regs.vh
// epas_regs.vh: constants of the external port access sequencer
// assumes inclusion by epas_top.v only; definitions only
// Functional notes
// - an access is stretched by programmed wait states, by ack, or by both.
// - ack is sampled on each rising port clock edge once the wait states have run out, and low stalls the access.
// - after ack is seen high again two more port clock cycles end the access.
// - with write hold set, write data stays driven one extra clock after strobe.
// - the port cycle clock is an internal divided enable, never on a pin.
// - on a write, chip select is released only after the write strobe.
// - on a read, the read strobe is deasserted before chip select is released.
// - on a write, data drives after strobe asserts and stops at access end.
`ifndef EPAS_REGS_VH
`define EPAS_REGS_VH
`define EPAS_ACK_TAIL     2'h2
`define EPAS_RATIO_W      4
`define EPAS_WAIT_W       4
`endif

// ===== epas_top.v
// epas_top.v: sequencer for read/write cycles on the external memory port
// assumes a single clk_i (peripheral clock); ack_i arrives from a pin
`timescale 1ns/100ps
`include "epas_regs.vh"
module epas_top #(
    parameter AW = 22,
    parameter DW = 16
) (
    input  wire                     clk_i,
    input  wire                     arst_n_i,
    input  wire                     ce_i,
    input  wire [`EPAS_RATIO_W-1:0] clk_ratio_i,
    input  wire [`EPAS_WAIT_W-1:0]  wait_states_i,
    input  wire                     ack_enable_i,
    input  wire                     write_data_hold_extend_i,
    input  wire                     req_i,
    input  wire                     req_write_i,
    input  wire [AW-1:0]            req_addr_i,
    input  wire [DW-1:0]            req_wdata_i,
    output reg                      busy_o,
    output reg                      done_o,
    output reg  [DW-1:0]            rdata_o,
    input  wire                     ack_i,
    input  wire [DW-1:0]            data_i,
    output reg  [DW-1:0]            data_o,
    output reg                      data_oe_o,
    output reg  [AW-1:0]            addr_o,
    output reg                      cs_n_o,
    output reg                      rd_n_o,
    output reg                      wr_n_o
);
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_SETUP  = 3'h1;
    localparam [2:0] ST_STROBE = 3'h2;
    localparam [2:0] ST_TAIL   = 3'h3;
    localparam [2:0] ST_HOLD   = 3'h4;
    localparam [2:0] ST_CSOFF  = 3'h5;

    localparam [`EPAS_RATIO_W-1:0] RATIO_ZERO = {`EPAS_RATIO_W{1'b0}};
    localparam [`EPAS_RATIO_W-1:0] RATIO_ONE  =
        {{(`EPAS_RATIO_W-1){1'b0}}, 1'b1};
    localparam [`EPAS_WAIT_W-1:0]  WAIT_ZERO  = {`EPAS_WAIT_W{1'b0}};
    localparam [`EPAS_WAIT_W-1:0]  WAIT_ONE   =
        {{(`EPAS_WAIT_W-1){1'b0}}, 1'b1};
    localparam [1:0]               TAIL_LAST  = `EPAS_ACK_TAIL - 2'h1;

    reg                     rst_s1_r;
    reg                     rst_n_r;
    reg                     ack_s1_r;
    reg                     ack_s2_r;
    reg [`EPAS_RATIO_W-1:0] div_r;
    reg [`EPAS_RATIO_W-1:0] div_nxt;
    reg                     pce_r;
    reg                     pce_nxt;
    reg [2:0]               st_r;
    reg [2:0]               st_nxt;
    reg [`EPAS_WAIT_W-1:0]  wcnt_r;
    reg [`EPAS_WAIT_W-1:0]  wcnt_nxt;
    reg [1:0]               tail_r;
    reg [1:0]               tail_nxt;
    reg                     wr_r;
    reg                     wr_nxt;
    reg                     busy_nxt;
    reg                     done_nxt;
    reg [DW-1:0]            rdata_nxt;
    reg [DW-1:0]            data_nxt;
    reg                     data_oe_nxt;
    reg [AW-1:0]            addr_nxt;
    reg                     cs_n_nxt;
    reg                     rd_n_nxt;
    reg                     wr_n_nxt;
    reg                     strobe_end;

    // state that follows the strobe release
    function [2:0] after_strobe;
        input is_write;
        input hold_ext;
        begin
            if (is_write && hold_ext)
                after_strobe = ST_HOLD;
            else
                after_strobe = ST_CSOFF;
        end
    endfunction

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else if (ce_i) begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ack pin synchroniser, idles at the ready level
    always @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ack_s1_r <= 1'b1;
            ack_s2_r <= 1'b1;
        end else if (ce_i) begin
            ack_s1_r <= ack_i;
            ack_s2_r <= ack_s1_r;
        end
    end

    // port cycle clock as a one-cycle enable every ratio+1 clocks
    always @* begin
        if (div_r >= clk_ratio_i) begin
            div_nxt = RATIO_ZERO;
            pce_nxt = 1'b1;
        end else begin
            div_nxt = div_r + RATIO_ONE;
            pce_nxt = 1'b0;
        end
    end

    always @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            div_r <= RATIO_ZERO;
            pce_r <= 1'b0;
        end else if (ce_i) begin
            div_r <= div_nxt;
            pce_r <= pce_nxt;
        end
    end

    always @* begin
        st_nxt      = st_r;
        wcnt_nxt    = wcnt_r;
        tail_nxt    = tail_r;
        wr_nxt      = wr_r;
        busy_nxt    = busy_o;
        done_nxt    = 1'b0;
        rdata_nxt   = rdata_o;
        data_nxt    = data_o;
        data_oe_nxt = data_oe_o;
        addr_nxt    = addr_o;
        cs_n_nxt    = cs_n_o;
        rd_n_nxt    = rd_n_o;
        wr_n_nxt    = wr_n_o;
        strobe_end  = 1'b0;
        case (st_r)
        ST_IDLE: begin
            if (req_i) begin
                addr_nxt = req_addr_i;
                cs_n_nxt = 1'b0;
                wr_nxt   = req_write_i;
                data_nxt = req_wdata_i;
                busy_nxt = 1'b1;
                st_nxt   = ST_SETUP;
            end
        end
        ST_SETUP: begin
            if (pce_r) begin
                rd_n_nxt = wr_r;
                wr_n_nxt = ~wr_r;
                wcnt_nxt = wait_states_i;
                st_nxt   = ST_STROBE;
            end
        end
        ST_STROBE: begin
            if (wr_r)
                data_oe_nxt = 1'b1;
            if (pce_r) begin
                if (wcnt_r != WAIT_ZERO)
                    wcnt_nxt = wcnt_r - WAIT_ONE;
                else if (ack_enable_i && !ack_s2_r)
                    st_nxt = ST_TAIL;
                else
                    strobe_end = 1'b1;
            end
        end
        ST_TAIL: begin
            // stalled until ack high, then two more port cycles
            if (pce_r) begin
                if (!ack_s2_r)
                    tail_nxt = 2'h0;
                else if (tail_r == TAIL_LAST) begin
                    tail_nxt   = 2'h0;
                    strobe_end = 1'b1;
                end else
                    tail_nxt = tail_r + 2'h1;
            end
        end
        ST_HOLD: begin
            st_nxt = ST_CSOFF;
        end
        ST_CSOFF: begin
            cs_n_nxt    = 1'b1;
            data_oe_nxt = 1'b0;
            busy_nxt    = 1'b0;
            done_nxt    = 1'b1;
            st_nxt      = ST_IDLE;
        end
        default: begin
            st_nxt = ST_IDLE;
        end
        endcase
        if (strobe_end) begin
            rdata_nxt = data_i;
            rd_n_nxt  = 1'b1;
            wr_n_nxt  = 1'b1;
            st_nxt    = after_strobe(wr_r, write_data_hold_extend_i);
        end
    end

    always @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r      <= ST_IDLE;
            wcnt_r    <= WAIT_ZERO;
            tail_r    <= 2'h0;
            wr_r      <= 1'b0;
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            rdata_o   <= {DW{1'b0}};
            data_o    <= {DW{1'b0}};
            data_oe_o <= 1'b0;
            addr_o    <= {AW{1'b0}};
            cs_n_o    <= 1'b1;
            rd_n_o    <= 1'b1;
            wr_n_o    <= 1'b1;
        end else if (ce_i) begin
            st_r      <= st_nxt;
            wcnt_r    <= wcnt_nxt;
            tail_r    <= tail_nxt;
            wr_r      <= wr_nxt;
            busy_o    <= busy_nxt;
            done_o    <= done_nxt;
            rdata_o   <= rdata_nxt;
            data_o    <= data_nxt;
            data_oe_o <= data_oe_nxt;
            addr_o    <= addr_nxt;
            cs_n_o    <= cs_n_nxt;
            rd_n_o    <= rd_n_nxt;
            wr_n_o    <= wr_n_nxt;
        end
    end
endmodule // epas_top

// ===== epas_top_props.sv
// epas_top_props.sv: port assertions for epas_top
// assumes a bind onto epas_top, one clock domain
`timescale 1ns/100ps
module epas_top_props #(parameter AW = 22) (
    input logic          clk_i,
    input logic          arst_n_i,
    input logic          ack_enable_i,
    input logic          write_data_hold_extend_i,
    input logic          ack_i,
    input logic          data_oe_o,
    input logic [AW-1:0] addr_o,
    input logic          cs_n_o,
    input logic          rd_n_o,
    input logic          wr_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    wire stb = !(rd_n_o && wr_n_o);
    AST_ADDR: assert property (stb |-> $stable(addr_o) && !cs_n_o)
        else $error("addr or cs moved");
    AST_WR_CS: assert property ($rose(cs_n_o) |-> $past(wr_n_o))
        else $error("cs before wr");
    AST_RD_CS: assert property ($rose(cs_n_o) |-> $past(rd_n_o))
        else $error("cs before rd");
    AST_OE_ON: assert property ($rose(data_oe_o) |-> $past(!wr_n_o))
        else $error("oe early");
    AST_OE_OFF: assert property ($rose(cs_n_o) |-> !data_oe_o)
        else $error("oe late");
    AST_HOLD0: assert property ($rose(wr_n_o) && !write_data_hold_extend_i
        |-> data_oe_o ##1 !data_oe_o) else $error("hold off");
    AST_HOLD1: assert property ($rose(wr_n_o) && write_data_hold_extend_i
        |-> data_oe_o [*2] ##1 !data_oe_o) else $error("hold on");
    AST_STALL: assert property (ack_enable_i && $past(!ack_i) && stb
        |=> stb) else $error("stall lost");
endmodule // epas_top_props
bind epas_top epas_top_props #(.AW(AW)) u_epas_top_props (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .ack_enable_i(ack_enable_i), .ack_i(ack_i),
    .write_data_hold_extend_i(write_data_hold_extend_i), .addr_o(addr_o),
    .data_oe_o(data_oe_o), .cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));

// ===== epas_mem_model.sv
// epas_mem_model.sv: small memory on the far side of the port
// assumes active-low selects and a stall control from the bench
`timescale 1ns/100ps
module epas_mem_model (
    input  logic        clk_i,
    input  logic        stall_i,
    input  logic [3:0]  addr_i,
    input  logic        cs_n_i,
    input  logic        rd_n_i,
    input  logic        oe_i,
    input  logic [15:0] data_i,
    output logic        ack_o,
    output logic [15:0] data_o
);
    logic [15:0] mem [16];
    assign ack_o = !stall_i;
    // released bus shows the inverse word
    assign data_o = (!cs_n_i && !rd_n_i) ? mem[addr_i] : ~mem[addr_i];
    always @(posedge clk_i) if (oe_i && !cs_n_i) mem[addr_i] <= data_i;
endmodule // epas_mem_model

// ===== tb_external_port_access_sequencer.sv
// tb_external_port_access_sequencer.sv: self-checking bench
// assumes epas_top, epas_mem_model and the bound checker
`timescale 1ns/100ps
module tb_external_port_access_sequencer;
    logic        clk = 0, rst_n = 0, ack_en = 0, hold = 0, req = 0, we = 0;
    logic        stall = 0, busy, done, oe, cs_n, rd_n, wr_n, ack;
    logic [3:0]  ratio = 0, waits = 0;
    logic [21:0] addr = 0, a_o;
    logic [15:0] wd = 0, rd, md, dout;
    int          err_count = 0, n_tests = 0, n;
    always #25 clk = ~clk;
    epas_top u_epas_top (.clk_i(clk), .arst_n_i(rst_n), .ce_i(1'b1),
        .clk_ratio_i(ratio), .wait_states_i(waits), .ack_enable_i(ack_en),
        .write_data_hold_extend_i(hold), .req_i(req), .req_write_i(we),
        .req_addr_i(addr), .req_wdata_i(wd), .busy_o(busy), .done_o(done),
        .rdata_o(rd), .ack_i(ack), .data_i(md), .data_o(dout),
        .data_oe_o(oe), .addr_o(a_o), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n));
    epas_mem_model u_epas_mem_model (.clk_i(clk), .stall_i(stall),
        .addr_i(a_o[3:0]), .cs_n_i(cs_n), .rd_n_i(rd_n), .oe_i(oe),
        .data_i(dout), .ack_o(ack), .data_o(md));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one access; n counts strobe-low cycles
    task xfer(input logic w, input logic [21:0] a, input logic [15:0] d);
        @(negedge clk) {req, we, addr, wd} = {1'b1, w, a, d};
        @(negedge clk) req = 0;
        n = 0;
        for (int k = 0; k < 600 && done !== 1'b1; k++) begin
            @(negedge clk);
            n += !(w ? wr_n : rd_n);
        end
        chk(done, 1);
        chk(busy, 0);
        chk(16'(a_o), 16'(a));
    endtask
    task t_timing;
        for (int r = 0; r < 4; r += 3)
            for (int w = 0; w < 16; w += 5) begin
                {ratio, waits} = {r[3:0], w[3:0]};
                xfer(1, 22'(r + w), 16'h5a00 + 16'(w));
                chk(16'(n), 16'((w + 1) * (r + 1)));
                xfer(0, 22'(r + w), 0);
                chk(rd, 16'h5a00 + 16'(w));
            end
    endtask
    task t_hold;
        {ratio, waits, hold} = 9'h001;
        xfer(1, 22'h3, 16'hc3a5);
        hold = 0;
        xfer(0, 22'h3, 0);
        chk(rd, 16'hc3a5);
    endtask
    task t_ack;
        for (int w = 0; w < 2; w++) begin
            {ack_en, stall, waits} = {2'b11, w[3:0]};
            fork
                xfer(0, 22'h3, 0);
                begin repeat (9) @(negedge clk); stall = 0; end
            join
            chk(16'(n >= 9 && n <= 17), 1);
            chk(rd, 16'hc3a5);
        end
        ack_en = 0;
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        t_timing;
        t_hold;
        t_ack;
        end_of_test;
    end
    initial begin
        #400000;
        err_count++;
        end_of_test;
    end
endmodule // tb_external_port_access_sequencer
